// ### core/scc_regs.svh
// Register offsets, field positions, reset values and counts of the control bank
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
`define SCC_ADDR_GEN_CFG 8'h80
`define SCC_ADDR_T1_ROW 8'h81
`define SCC_ADDR_T2_ROW 8'h82
`define SCC_ADDR_C1_CODE 8'h83
`define SCC_ADDR_C2_CODE 8'h84
`define SCC_ADDR_OVR_SEL 8'h85
`define SCC_ADDR_PERMIT 8'h86
`define SCC_ADDR_ADC 8'h87
`define SCC_ADDR_RSV_LO 8'h88
`define SCC_ADDR_RSV_HI 8'h8f
`define SCC_BIT_REF_MODE 2
`define SCC_BIT_FILT_DIS 4
`define SCC_BIT_PERSIST 5
`define SCC_BIT_GEN1_POL 6
`define SCC_BIT_GEN2_POL 7
`define SCC_BIT_T1_OVR 4
`define SCC_BIT_C1_OVR 5
`define SCC_BIT_T2_OVR 6
`define SCC_BIT_C2_OVR 7
`define SCC_BIT_PERMIT 7
`define SCC_CFG_FIXED_MASK 8'h0b
`define SCC_CFG_FIXED_VAL 8'h08
`define SCC_ROW_MASK 8'h3f
`define SCC_OVR_MASK 8'hf0
`define SCC_PERMIT_MASK 8'h80
`define SCC_PERMIT_SET 8'h80
`define SCC_PERMIT_CLR 8'h00
`define SCC_FILT_COUNT 3'h4
`endif

// ### core/scc_pkg.sv
// Types shared by the control register bank
package scc_pkg;
  typedef enum logic [1:0] {
    SCC_IDLE = 2'b00,
    SCC_WRITE = 2'b01,
    SCC_DONE = 2'b11
  } scc_wr_state_t;
endpackage : scc_pkg

// ### core/scc_conv_filter.sv
// Result filter: passes a conversion on when stable or when filtering is off
`timescale 1ns/100ps
`default_nettype none
`include "scc_regs.svh"
module scc_conv_filter #(
  parameter int DATA_W = 8,
  parameter int KEEP_W = 6
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Async reset, high
  input wire logic conv_valid, // One conversion done, pulse
  input wire logic [DATA_W-1:0] conv_data, // Conversion result
  input wire logic filter_disable, // 1: update on every conversion
  output logic upd_valid, // Update the status byte, pulse
  output logic [DATA_W-1:0] upd_data // Value to store
);
  // Refuse a kept width the result cannot hold
  if (KEEP_W > DATA_W || KEEP_W < 1) begin : g_bad_keep
    $error("KEEP_W out of range");
  end

  logic [KEEP_W-1:0] last_r, last_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic upd_valid_nxt;
  logic [DATA_W-1:0] upd_data_nxt;
  logic same;

  // ----------------------------------------
  // Match counting
  // ----------------------------------------
  // Count conversions agreeing on upper bits
  always_comb begin
    last_nxt = last_r;
    cnt_nxt = cnt_r;
    upd_valid_nxt = 1'b0;
    upd_data_nxt = upd_data;
    same = conv_data[DATA_W-1 -: KEEP_W] == last_r;
    if (conv_valid) begin
      last_nxt = conv_data[DATA_W-1 -: KEEP_W];
      if (filter_disable) begin
        upd_valid_nxt = 1'b1;
        upd_data_nxt = conv_data;
        cnt_nxt = 3'h1;
      end else begin
        cnt_nxt = (same && cnt_r != 3'h0) ? cnt_r + 3'h1 : 3'h1;
        if (cnt_nxt >= `SCC_FILT_COUNT) begin
          upd_valid_nxt = 1'b1;
          upd_data_nxt = conv_data;
          cnt_nxt = 3'h0;
        end
      end
    end
  end

  // Register filter state
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      last_r <= '0;
      cnt_r <= 3'h0;
      upd_valid <= 1'b0;
      upd_data <= '0;
    end else begin
      last_r <= last_nxt;
      cnt_r <= cnt_nxt;
      upd_valid <= upd_valid_nxt;
      upd_data <= upd_data_nxt;
    end
  end
endmodule : scc_conv_filter
`default_nettype wire

// ### core/scc_ctrl_bank.sv
// Control and status register bank of the sensor conditioner
// Function
// - Reference pin mode bit 0 drives internal reference out; 1 takes external.
// - With filter disabled, status byte refreshes on every conversion.
// - Filter enabled: update only after four conversions agreeing in upper six bits.
// - Persistence bit 0: direct registers 1-4 written to volatile copy only.
// - Persistence bit 1: direct registers 1-4 written to volatile and nonvolatile.
// - Generator 1 polarity bit: 0 source, 1 sink.
// - Bit 7 of 86h is the write permit latch; 1 enables writes.
// - Generator 2 polarity bit: 0 source, 1 sink.
// - With latch clear, writes other than to 86h are aborted and the data byte is not acknowledged.
// - Latch resets clear; 80h sets, 00h clears, other bits untouched.
// - Upper six ADC bits select table rows unless row override enabled.
`timescale 1ns/100ps
`default_nettype none
`include "scc_regs.svh"
module scc_ctrl_bank #(
  parameter int DATA_W = 8,
  parameter int ROW_W = 6
) (
  input wire logic clk_sys, // System clock, 20 MHz
  input wire logic reset, // Async reset, high
  input wire logic wr_req, // Byte write request, pulse
  input wire logic rd_req, // Byte read request, pulse
  input wire logic [7:0] addr, // Byte address
  input wire logic [7:0] wr_data, // Write data byte
  output logic [7:0] rd_data, // Read data, held
  output logic rd_valid, // Read data valid, pulse
  output logic wr_ack, // Write acknowledged, pulse
  output logic wr_nak, // Write refused, pulse
  input wire logic [7:0] nv_cfg_in, // Stored config byte
  input wire logic [7:0] nv_sel_in, // Stored override select byte
  input wire logic [31:0] nv_direct_in, // Stored bytes 81h-84h, 81h low
  input wire logic nv_load, // Load stored bytes into working copies, pulse
  output logic nv_commit, // Commit one byte to storage, pulse
  output logic [7:0] nv_addr, // Committed byte address
  output logic [7:0] nv_data, // Committed byte value
  input wire logic conv_valid, // Conversion done, pulse
  input wire logic [DATA_W-1:0] conv_data, // Conversion result
  output logic ref_pin_mode, // 1: external reference input
  output logic ref_drive_en, // 1: drive pin from internal reference
  output logic conv_filter_disable, // Filter off
  output logic direct_regs_persist, // Direct registers nonvolatile
  output logic gen1_polarity, // Generator 1: 0 source, 1 sink
  output logic gen2_polarity, // Generator 2: 0 source, 1 sink
  output logic [ROW_W-1:0] table1_row, // Table 1 row in use
  output logic [ROW_W-1:0] table2_row, // Table 2 row in use
  output logic conv1_override_en, // Converter 1 takes direct code
  output logic conv2_override_en, // Converter 2 takes direct code
  output logic [7:0] conv1_code, // Converter 1 direct code
  output logic [7:0] conv2_code, // Converter 2 direct code
  output logic write_permit_latch // Write permit state
);
  // Refuse widths the byte-wide bank cannot serve
  if (DATA_W != 8 || ROW_W != 6) begin : g_bad_width
    $error("Bank serves 8-bit results, 6-bit rows only");
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] sel_r, sel_nxt;
  logic [7:0] dir_r [4];
  logic [7:0] dir_nxt [4];
  logic permit_r, permit_nxt;
  logic [7:0] adc_r, adc_nxt;
  logic [7:0] rd_data_nxt;
  logic rd_valid_nxt, wr_ack_nxt, wr_nak_nxt;
  logic commit_nxt;
  logic [7:0] nv_addr_nxt, nv_data_nxt;
  scc_pkg::scc_wr_state_t st_r, st_nxt;
  logic filt_upd;
  logic [7:0] filt_data;
  logic [ROW_W-1:0] t1_nxt, t2_nxt;

  // True for the address of a direct register, 81h-84h
  function automatic logic is_direct(input logic [7:0] a);
    is_direct = (a >= `SCC_ADDR_T1_ROW) && (a <= `SCC_ADDR_C2_CODE);
  endfunction : is_direct

  // Mask of writable bits for a byte
  function automatic logic [7:0] wr_mask(input logic [7:0] a);
    case (a)
      `SCC_ADDR_T1_ROW, `SCC_ADDR_T2_ROW: wr_mask = `SCC_ROW_MASK;
      `SCC_ADDR_OVR_SEL: wr_mask = `SCC_OVR_MASK;
      default: wr_mask = 8'hff;
    endcase
  endfunction : wr_mask

  // Result filter
  scc_conv_filter #(
    .DATA_W(DATA_W),
    .KEEP_W(ROW_W)
  ) u_filter (
    .clk_sys(clk_sys),
    .reset(reset),
    .conv_valid(conv_valid),
    .conv_data(conv_data),
    .filter_disable(cfg_r[`SCC_BIT_FILT_DIS]),
    .upd_valid(filt_upd),
    .upd_data(filt_data)
  );

  // ----------------------------------------
  // Write and read handling
  // ----------------------------------------
  // Next register values and bus answers
  always_comb begin
    cfg_nxt = cfg_r;
    sel_nxt = sel_r;
    for (int i = 0; i < 4; i++) begin
      dir_nxt[i] = dir_r[i];
    end
    permit_nxt = permit_r;
    adc_nxt = adc_r;
    rd_data_nxt = rd_data;
    rd_valid_nxt = 1'b0;
    wr_ack_nxt = 1'b0;
    wr_nak_nxt = 1'b0;
    commit_nxt = 1'b0;
    nv_addr_nxt = nv_addr;
    nv_data_nxt = nv_data;
    st_nxt = scc_pkg::SCC_IDLE;
    if (filt_upd) begin
      adc_nxt = filt_data;
    end
    if (nv_load) begin
      cfg_nxt = (nv_cfg_in & ~`SCC_CFG_FIXED_MASK) | `SCC_CFG_FIXED_VAL;
      sel_nxt = nv_sel_in & `SCC_OVR_MASK;
      for (int i = 0; i < 4; i++) begin
        dir_nxt[i] = nv_direct_in[8*i +: 8] & wr_mask(8'(`SCC_ADDR_T1_ROW + i));
      end
    end else if (wr_req) begin
      st_nxt = scc_pkg::SCC_WRITE;
      if (addr == `SCC_ADDR_PERMIT) begin
        // Latch always writable so it can be set
        if (wr_data == `SCC_PERMIT_SET) begin
          permit_nxt = 1'b1;
        end else if (wr_data == `SCC_PERMIT_CLR) begin
          permit_nxt = 1'b0;
        end
        wr_ack_nxt = 1'b1;
      end else if (!permit_r) begin
        wr_nak_nxt = 1'b1;
      end else begin
        wr_ack_nxt = 1'b1;
        case (addr)
          `SCC_ADDR_GEN_CFG: begin
            cfg_nxt = (wr_data & ~`SCC_CFG_FIXED_MASK) | `SCC_CFG_FIXED_VAL;
            commit_nxt = 1'b1;
          end
          `SCC_ADDR_OVR_SEL: begin
            sel_nxt = wr_data & `SCC_OVR_MASK;
            commit_nxt = 1'b1;
          end
          default: begin
            // Status and reserved bytes ignore writes
            commit_nxt = 1'b0;
          end
        endcase
        if (is_direct(addr)) begin
          dir_nxt[2'(addr - `SCC_ADDR_T1_ROW)] = wr_data & wr_mask(addr);
          commit_nxt = cfg_r[`SCC_BIT_PERSIST];
        end
        nv_addr_nxt = addr;
        nv_data_nxt = wr_data & wr_mask(addr);
      end
    end else if (rd_req) begin
      rd_valid_nxt = 1'b1;
      case (addr)
        `SCC_ADDR_GEN_CFG: rd_data_nxt = cfg_r;
        `SCC_ADDR_OVR_SEL: rd_data_nxt = sel_r;
        `SCC_ADDR_PERMIT: rd_data_nxt = {permit_r, 7'h00};
        `SCC_ADDR_ADC: rd_data_nxt = adc_r;
        default: rd_data_nxt = is_direct(addr) ? dir_r[2'(addr - `SCC_ADDR_T1_ROW)] : 8'h00;
      endcase
    end
    if (st_r == scc_pkg::SCC_WRITE) begin
      st_nxt = scc_pkg::SCC_DONE;
    end
  end

  // Table row steering
  always_comb begin
    t1_nxt = sel_r[`SCC_BIT_T1_OVR] ? dir_r[0][ROW_W-1:0] : adc_r[7 -: ROW_W];
    t2_nxt = sel_r[`SCC_BIT_T2_OVR] ? dir_r[1][ROW_W-1:0] : adc_r[7 -: ROW_W];
  end

  // Register state and outputs
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cfg_r <= `SCC_CFG_FIXED_VAL;
      sel_r <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        dir_r[i] <= 8'h00;
      end
      permit_r <= 1'b0;
      adc_r <= 8'h00;
      st_r <= scc_pkg::SCC_IDLE;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      wr_ack <= 1'b0;
      wr_nak <= 1'b0;
      nv_commit <= 1'b0;
      nv_addr <= 8'h00;
      nv_data <= 8'h00;
      ref_pin_mode <= 1'b0;
      ref_drive_en <= 1'b1;
      conv_filter_disable <= 1'b0;
      direct_regs_persist <= 1'b0;
      gen1_polarity <= 1'b0;
      gen2_polarity <= 1'b0;
      table1_row <= '0;
      table2_row <= '0;
      conv1_override_en <= 1'b0;
      conv2_override_en <= 1'b0;
      conv1_code <= 8'h00;
      conv2_code <= 8'h00;
      write_permit_latch <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      sel_r <= sel_nxt;
      for (int i = 0; i < 4; i++) begin
        dir_r[i] <= dir_nxt[i];
      end
      permit_r <= permit_nxt;
      adc_r <= adc_nxt;
      st_r <= st_nxt;
      rd_data <= rd_data_nxt;
      rd_valid <= rd_valid_nxt;
      wr_ack <= wr_ack_nxt;
      wr_nak <= wr_nak_nxt;
      nv_commit <= commit_nxt;
      nv_addr <= nv_addr_nxt;
      nv_data <= nv_data_nxt;
      ref_pin_mode <= cfg_r[`SCC_BIT_REF_MODE];
      ref_drive_en <= ~cfg_r[`SCC_BIT_REF_MODE];
      conv_filter_disable <= cfg_r[`SCC_BIT_FILT_DIS];
      direct_regs_persist <= cfg_r[`SCC_BIT_PERSIST];
      gen1_polarity <= cfg_r[`SCC_BIT_GEN1_POL];
      gen2_polarity <= cfg_r[`SCC_BIT_GEN2_POL];
      table1_row <= t1_nxt;
      table2_row <= t2_nxt;
      conv1_override_en <= sel_r[`SCC_BIT_C1_OVR];
      conv2_override_en <= sel_r[`SCC_BIT_C2_OVR];
      conv1_code <= dir_r[2];
      conv2_code <= dir_r[3];
      write_permit_latch <= permit_r;
    end
  end
endmodule : scc_ctrl_bank
`default_nettype wire

// ### tb/scc_ctrl_bank_props.sv
// Port assertions for the control and status register bank
`timescale 1ns/100ps
`default_nettype none
module scc_ctrl_bank_props (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Async reset, high
  input wire logic wr_req, // Write request
  input wire logic rd_req, // Read request
  input wire logic nv_load, // Stored copy recall
  input wire logic [7:0] addr, // Byte address
  input wire logic [7:0] wr_data, // Write byte
  input wire logic [7:0] rd_data, // Read byte
  input wire logic rd_valid, // Read answer
  input wire logic wr_ack, // Write accepted
  input wire logic wr_nak, // Write refused
  input wire logic nv_commit, // Commit pulse
  input wire logic [7:0] nv_addr, // Commit address
  input wire logic ref_pin_mode, // Reference mode
  input wire logic ref_drive_en, // Reference drive
  input wire logic direct_regs_persist, // Persist mode
  input wire logic gen1_polarity, // Generator 1 polarity
  input wire logic gen2_polarity, // Generator 2 polarity
  input wire logic write_permit_latch // Permit latch
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  logic wr_go; // Write taken at this edge
  logic direct; // Address among the direct registers
  assign wr_go = wr_req && !nv_load;
  assign direct = (addr >= 8'h81) && (addr <= 8'h84);
  // Config bit shows two cycles after an accepted write
  property cfg_p(bit_val, logic [7:0] m);
    wr_go && addr == 8'h80 ##1 wr_ack |=> (bit_val == |($past(wr_data, 2) & m));
  endproperty
  AST_REF_DRIVE: assert property (ref_drive_en == !ref_pin_mode)
    else $error("reference drive not opposite of pin mode");
  AST_REF_MODE: assert property (cfg_p(ref_pin_mode, 8'h04))
    else $error("pin mode not taken from write");
  AST_GEN1: assert property (cfg_p(gen1_polarity, 8'h40))
    else $error("generator 1 polarity not taken from write");
  AST_GEN2: assert property (cfg_p(gen2_polarity, 8'h80))
    else $error("generator 2 polarity not taken from write");
  AST_NAK: assert property (wr_go && addr != 8'h86 ##1 !write_permit_latch |->
    wr_nak && !wr_ack && !nv_commit) else $error("write not refused with latch clear");
  AST_ACK: assert property (wr_go ##1 write_permit_latch |-> wr_ack && !wr_nak)
    else $error("write refused with latch set");
  AST_LATCH_SET: assert property (wr_go && addr == 8'h86 && wr_data == 8'h80 |=>
    wr_ack ##1 write_permit_latch) else $error("latch not set");
  AST_VOLATILE: assert property (wr_go && direct ##1 !direct_regs_persist |-> !nv_commit)
    else $error("commit while volatile");
  AST_NV_BOTH: assert property (wr_go && direct ##1 (wr_ack && direct_regs_persist) |->
    nv_commit && nv_addr == $past(addr)) else $error("missing commit while persistent");
  AST_COMMIT_NOW: assert property (wr_go && addr == 8'h80 ##1 wr_ack |->
    nv_commit && nv_addr == 8'h80) else $error("config write not committed");
  AST_RO: assert property (wr_go && addr == 8'h87 |=> !nv_commit)
    else $error("status write committed");
  AST_RSV: assert property (rd_req && !wr_req && !nv_load && addr[7:3] == 5'h11 |=>
    rd_valid && rd_data == 8'h00) else $error("reserved read not zero");
  COV_NAK: cover property (wr_nak);
  COV_NV: cover property (nv_commit && nv_addr == 8'h83);
  COV_RD: cover property (rd_valid && rd_data != 8'h00);
endmodule : scc_ctrl_bank_props
bind scc_ctrl_bank scc_ctrl_bank_props u_props (.clk_sys, .reset, .wr_req, .rd_req, .nv_load,
  .addr, .wr_data, .rd_data, .rd_valid, .wr_ack, .wr_nak, .nv_commit, .nv_addr, .ref_pin_mode,
  .ref_drive_en, .direct_regs_persist, .gen1_polarity, .gen2_polarity, .write_permit_latch);
`default_nettype wire

// ### tb/scc_host_model.sv
// Host model issuing single-byte writes and reads
`timescale 1ns/100ps
`default_nettype none
module scc_host_model (
  input wire logic clk_sys, // System clock
  output logic wr_req, // Write request pulse
  output logic rd_req, // Read request pulse
  output logic [7:0] addr, // Byte address
  output logic [7:0] wr_data, // Write byte
  input wire logic [7:0] rd_data, // Read byte
  input wire logic rd_valid, // Read answer
  input wire logic wr_ack, // Write accepted
  input wire logic wr_nak, // Write refused
  input wire logic nv_commit // Commit pulse
);
  initial begin
    wr_req = 1'b0;
    rd_req = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
  end
  // One write; answer is {commit, refused, accepted}
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [2:0] r);
    @(posedge clk_sys);
    wr_req <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_req <= 1'b0;
    addr <= ~a; // Released lines carry no stale value
    wr_data <= ~d;
    @(posedge clk_sys); // Answer stands from the edge after the request
    r = {nv_commit, wr_nak, wr_ack};
  endtask : wr
  // Config write with the fixed bits at their constants
  task automatic cfg(input logic [7:0] d, output logic [2:0] r);
    wr(8'h80, (d & 8'hf4) | 8'h08, r);
  endtask : cfg
  // One read; unknown if no answer came
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    rd_req <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_req <= 1'b0;
    addr <= ~a;
    @(posedge clk_sys); // Read data stands from the edge after the request
    d = rd_valid ? rd_data : 8'hxx;
  endtask : rd
endmodule : scc_host_model
`default_nettype wire

// ### tb/sensor_conditioner_control_regs_test.sv
// Self-checking bench for the control and status register bank
`timescale 1ns/100ps
`default_nettype none
module sensor_conditioner_control_regs_test;
  logic clk_sys, reset, wr_req, rd_req, rd_valid, wr_ack, wr_nak, nv_commit, conv_valid;
  logic [7:0] addr, wr_data, rd_data, nv_addr, nv_data, conv_data, conv1_code, conv2_code, d, v, m;
  logic ref_pin_mode, ref_drive_en, conv_filter_disable, direct_regs_persist, gen1_polarity;
  logic gen2_polarity, conv1_override_en, conv2_override_en, write_permit_latch;
  logic [5:0] table1_row, table2_row;
  logic [2:0] r;
  logic nv_load;
  logic [7:0] nv_cfg_in, nv_sel_in;
  logic [31:0] nv_direct_in;
  logic [31:0] seed = 32'hd417;
  int n_errors = 0;
  int n_tests = 0;
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  scc_ctrl_bank u_scc_ctrl_bank (.clk_sys, .reset, .wr_req, .rd_req, .addr, .wr_data, .rd_data,
    .rd_valid, .wr_ack, .wr_nak, .nv_cfg_in, .nv_sel_in, .nv_direct_in,
    .nv_load, .nv_commit, .nv_addr, .nv_data, .conv_valid, .conv_data, .ref_pin_mode,
    .ref_drive_en, .conv_filter_disable, .direct_regs_persist, .gen1_polarity, .gen2_polarity,
    .table1_row, .table2_row, .conv1_override_en, .conv2_override_en, .conv1_code, .conv2_code,
    .write_permit_latch);
  scc_host_model u_scc_host_model (.clk_sys, .wr_req, .rd_req, .addr, .wr_data, .rd_data,
    .rd_valid, .wr_ack, .wr_nak, .nv_commit);
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : xs
  function automatic logic [7:0] cfg_exp(input logic [7:0] w);
    return (w & 8'hf4) | 8'h08;
  endfunction : cfg_exp
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask : chk
  // One conversion pulse, then time for status and rows to settle
  task automatic conv(input logic [7:0] c);
    @(posedge clk_sys);
    conv_valid <= 1'b1;
    conv_data <= c;
    @(posedge clk_sys);
    conv_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : conv
  task automatic complete_run();
    if (n_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    complete_run();
  end
  initial begin
    reset = 1'b1;
    conv_valid = 1'b0;
    conv_data = 8'h00;
    nv_load = 1'b0;
    nv_cfg_in = 8'h00;
    nv_sel_in = 8'h00;
    nv_direct_in = 32'h0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    // Out of reset: latch clear, writes refused
    chk({7'h0, ref_drive_en}, 8'h01);
    u_scc_host_model.rd(8'h80, d);
    chk(d, 8'h08);
    u_scc_host_model.wr(8'h83, 8'h5a, r);
    chk({5'h0, r}, 8'h02);
    u_scc_host_model.rd(8'h83, d);
    chk(d, 8'h00);
    u_scc_host_model.wr(8'h86, 8'h80, r);
    chk({5'h0, r}, 8'h01);
    u_scc_host_model.wr(8'h86, 8'h5a, r);
    u_scc_host_model.rd(8'h86, d);
    chk(d, 8'h80);
    chk({7'h0, write_permit_latch}, 8'h01);
    // Random configs, each followed by a direct register write
    for (int i = 0; i < 12; i++) begin
      v = xs();
      u_scc_host_model.cfg(v, r);
      chk({5'h0, r}, 8'h05);
      u_scc_host_model.rd(8'h80, d);
      chk(d, cfg_exp(v));
      chk({gen2_polarity, gen1_polarity, direct_regs_persist, conv_filter_disable, 1'b1,
        ref_pin_mode, 2'b00}, cfg_exp(v));
      m = xs();
      u_scc_host_model.wr(8'h83, m, r);
      chk({5'h0, r}, {5'h0, v[5], 2'b01});
      u_scc_host_model.rd(8'h83, d);
      chk(d, m);
      chk(conv1_code, m);
    end
    u_scc_host_model.wr(8'h8a, 8'h77, r);
    u_scc_host_model.rd(8'h8a, d);
    chk(d, 8'h00);
    // Filter on: a mismatch restarts the run of four
    u_scc_host_model.cfg(8'h00, r);
    v = xs() | 8'h80;
    for (int i = 0; i < 6; i++) begin
      conv(i < 3 ? v ^ 8'(i) : v ^ 8'h04 ^ 8'(i & 3));
    end
    u_scc_host_model.rd(8'h87, d);
    chk(d, 8'h00);
    conv(v ^ 8'h06);
    u_scc_host_model.rd(8'h87, d);
    chk(d, v ^ 8'h06);
    chk({2'b00, table1_row}, {2'b00, (v[7:2] ^ 6'h01)});
    // Filter off: every conversion lands
    u_scc_host_model.cfg(8'h10, r);
    for (int i = 0; i < 3; i++) begin
      m = xs();
      conv(m);
      u_scc_host_model.rd(8'h87, d);
      chk(d, m);
      chk({2'b00, table2_row}, {2'b00, m[7:2]});
    end
    u_scc_host_model.wr(8'h87, ~m, r);
    u_scc_host_model.rd(8'h87, d);
    chk(d, m);
    u_scc_host_model.wr(8'h81, 8'h2b, r);
    u_scc_host_model.wr(8'h85, 8'h10, r);
    u_scc_host_model.rd(8'h85, d);
    chk({2'b00, table1_row}, 8'h2b);
    chk(d, 8'h10);
    // Direct bytes and override selects reach the outputs
    m = xs();
    u_scc_host_model.wr(8'h84, m, r);
    chk({5'h0, r}, 8'h01);
    u_scc_host_model.wr(8'h82, 8'hff, r);
    u_scc_host_model.wr(8'h85, 8'hff, r);
    chk({5'h0, r}, 8'h05);
    chk(nv_addr, 8'h85);
    chk(nv_data, 8'hf0);
    u_scc_host_model.rd(8'h82, d);
    chk(d, 8'h3f);
    chk({2'b00, table2_row}, 8'h3f);
    chk({6'h0, conv2_override_en, conv1_override_en}, 8'h03);
    chk(conv2_code, m);
    // Recall of stored copies overwrites the working bytes
    v = xs();
    m = xs();
    @(posedge clk_sys);
    nv_load <= 1'b1;
    nv_cfg_in <= v;
    nv_sel_in <= m;
    nv_direct_in <= {xs(), xs(), xs(), xs()};
    @(posedge clk_sys);
    nv_load <= 1'b0;
    u_scc_host_model.rd(8'h80, d);
    chk(d, cfg_exp(v));
    u_scc_host_model.rd(8'h85, d);
    chk(d, m & 8'hf0);
    u_scc_host_model.rd(8'h81, d);
    chk(d, nv_direct_in[7:0] & 8'h3f);
    u_scc_host_model.rd(8'h84, d);
    chk(d, nv_direct_in[31:24]);
    // Reset in mid-run clears the latch again
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    chk({7'h0, write_permit_latch}, 8'h00);
    u_scc_host_model.wr(8'h83, 8'h33, r);
    chk({5'h0, r}, 8'h02);
    u_scc_host_model.rd(8'h80, d);
    chk(d, 8'h08);
    u_scc_host_model.wr(8'h86, 8'h80, r);
    chk({5'h0, r}, 8'h01);
    // Clearing the latch refuses writes again
    u_scc_host_model.wr(8'h86, 8'h00, r);
    u_scc_host_model.wr(8'h84, 8'h11, r);
    chk({5'h0, r}, 8'h02);
    chk({7'h0, write_permit_latch}, 8'h00);
    complete_run();
  end
endmodule : sensor_conditioner_control_regs_test
`default_nettype wire
